// ==== rsh_defines.svh ====
/*
 Constants of the serial slave request handler: framing, timing, function
 and exception codes, coil encodings and checksum parameters.
 Assumes inclusion by bare name into every file that needs a constant.
*/
// Contract
// - Characters go out start bit first, then data bits from LSB to MSB.
// - No parity means two stop bits; parity means parity then one stop.
// - Address field is eight bits; individual slaves use addresses 1 to 247.
// - Every response carries this slave's own configured address.
// - Address zero is accepted as broadcast besides the own address.
// - Nothing is ever sent back for a broadcast request.
// - Data item addresses are zero based within the function's group.
// - Function codes 01,03,04,05,06,08,0F,10,11 are supported, nothing else.
// - Reset and identification functions touch no register or coil.
// - A good response echoes the request function code unchanged.
// - An exception sets the code's top bit and adds a reason byte.
// - Coil read reports output drive state; not executed when broadcast.
// - Coil read has 16-bit start and count; coils are 0 to 3.
// - Coils pack one per bit, first coil in LSB; one means sinking.
// - Unused high bits of the coil byte read as zero.
// - Holding register read from zero-based start; not executed on broadcast.
// - Registers return high byte then low byte, in ascending order.
// - Read request is address, code, start hi/lo, quantity hi/lo, check.
// - Frames are framed by at least 3.5 character times of silence.
// - Idle over 1.5 characters mid-frame flushes it; next byte is address.
// - Every frame ends with a 16-bit check the receiver verifies.
`ifndef RSH_DEFINES_SVH
`define RSH_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSH_CLK_HZ 100000000
`define RSH_BAUD 9600
`define RSH_CHAR_BITS 11
`define RSH_GAP_TENTHS 15
`define RSH_SIL_TENTHS 35
`define RSH_BIT_CYC (`RSH_CLK_HZ / `RSH_BAUD)
`define RSH_GAP_CYC ((`RSH_BIT_CYC * `RSH_CHAR_BITS * `RSH_GAP_TENTHS + 9) / 10)
`define RSH_SIL_CYC ((`RSH_BIT_CYC * `RSH_CHAR_BITS * `RSH_SIL_TENTHS + 9) / 10)

// ----------------------------------------
// Addresses, codes and values
// ----------------------------------------
`define RSH_BCAST 8'h00
`define RSH_ADDR_MAX 8'hf7
`define RSH_FC_RD_COIL 8'h01
`define RSH_FC_RD_HOLD 8'h03
`define RSH_FC_RD_IN 8'h04
`define RSH_FC_WR_COIL 8'h05
`define RSH_FC_WR_REG 8'h06
`define RSH_FC_RESET 8'h08
`define RSH_FC_WR_COILS 8'h0f
`define RSH_FC_WR_REGS 8'h10
`define RSH_FC_REP_ID 8'h11
`define RSH_EXC_FLAG 8'h80
`define RSH_EXC_FUNC 8'h01
`define RSH_EXC_ADDR 8'h02
`define RSH_EXC_VAL 8'h03
`define RSH_NUM_COILS 4
`define RSH_COIL_ON 16'hff00
`define RSH_COIL_OFF 16'h0000
`define RSH_RUN_ON 8'hff
`define RSH_CRC_POLY 16'ha001
`define RSH_CRC_INIT 16'hffff

`endif

// ==== rsh_pkg.sv ====
/*
 Types of the serial slave request handler.
 Assumes nothing beyond the constants header.
*/
package rsh_pkg;

	typedef enum logic [2:0] {
		RSH_SYNC,
		RSH_RECV,
		RSH_EXEC,
		RSH_TX
	} rsh_state_type;

endpackage

// ==== rsh_char_if.sv ====
/*
 Character stream between the line serializer and the frame handler.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface rsh_char_if;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       rx_err;
	logic       rx_busy;
	logic       tx_valid;
	logic [7:0] tx_data;
	logic       tx_ready;
	logic       tx_busy;
	logic       parity_en;
	logic       parity_odd;

	modport line (output rx_valid, rx_data, rx_err, rx_busy, tx_ready, tx_busy,
		input tx_valid, tx_data, parity_en, parity_odd);
	modport core (input rx_valid, rx_data, rx_err, rx_busy, tx_ready, tx_busy,
		output tx_valid, tx_data, parity_en, parity_odd);
endinterface

// ==== rsh_crc16.sv ====
/*
 One byte step of the reflected CRC-16.
 Assumes the caller holds the running value in its own register.
*/
`timescale 1ns/100ps
`include "rsh_defines.svh"
module rsh_crc16 (
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc_out
);
	logic [15:0] stage [9];

	assign stage[0] = crc_in ^ {8'h00, data};
	generate
		for (genvar i = 0; i < 8; i++)
		begin : g_bit
			assign stage[i + 1] = stage[i][0] ? ((stage[i] >> 1) ^ `RSH_CRC_POLY)
				: (stage[i] >> 1);
		end
	endgenerate
	assign crc_out = stage[8];
endmodule

// ==== rsh_uart.sv ====
/*
 Line serializer: eleven-bit characters in both directions.
 Assumes an idle-high receive pin from outside the clock domain.
*/
`timescale 1ns/100ps
`include "rsh_defines.svh"
module rsh_uart #(
	parameter int BIT_CYC = `RSH_BIT_CYC
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic line_rx,
	output logic      line_tx,
	rsh_char_if.line  chr
);
	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	logic        rx_meta;
	logic        rx_sync;
	logic        rx_act;
	logic [31:0] rx_cnt;
	logic [3:0]  rx_bit;
	logic [9:0]  rx_sh;
	wire         rx_tick = rx_act && rx_cnt == 32'h0;
	wire         rx_last = rx_tick && rx_bit == 4'ha;
	wire         par_bad = chr.parity_en && ((^rx_sh[8:1]) ^ chr.parity_odd ^ rx_sh[9]);
	wire         stop_bad = !rx_sync || (!chr.parity_en && !rx_sh[9]);

	always_ff @(posedge ref_clk)
	begin
		rx_meta <= line_rx;
		rx_sync <= rx_meta;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_act <= 1'b0;
			rx_cnt <= 32'h0;
			rx_bit <= 4'h0;
			rx_sh <= 10'h000;
		end
		else if (!rx_act)
		begin
			rx_act <= !rx_sync;
			rx_cnt <= 32'(BIT_CYC / 2);
			rx_bit <= 4'h0;
		end
		else if (rx_tick)
		begin
			rx_cnt <= 32'(BIT_CYC - 1);
			rx_bit <= rx_bit + 4'h1;
			rx_sh <= {rx_sync, rx_sh[9:1]};
			if ((rx_bit == 4'h0 && rx_sync) || rx_last)
				rx_act <= 1'b0;
		end
		else
			rx_cnt <= rx_cnt - 32'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		chr.rx_valid <= !reset && rx_last;
		if (rx_last)
		begin
			chr.rx_data <= rx_sh[8:1];
			chr.rx_err <= par_bad || stop_bad;
		end
	end
	assign chr.rx_busy = rx_act;

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	logic        tx_act;
	logic [31:0] tx_cnt;
	logic [3:0]  tx_bit;
	logic [10:0] tx_sh;
	wire         tx_par = (^chr.tx_data) ^ chr.parity_odd;
	wire         tx_mid = chr.parity_en ? tx_par : 1'b1;

	assign chr.tx_ready = !tx_act;
	assign chr.tx_busy = tx_act;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			tx_act <= 1'b0;
			tx_cnt <= 32'h0;
			tx_bit <= 4'h0;
			tx_sh <= 11'h7ff;
			line_tx <= 1'b1;
		end
		else if (!tx_act)
		begin
			line_tx <= 1'b1;
			if (chr.tx_valid)
			begin
				tx_act <= 1'b1;
				tx_cnt <= 32'(BIT_CYC - 1);
				tx_bit <= 4'h0;
				tx_sh <= {1'b1, tx_mid, chr.tx_data, 1'b0};
			end
		end
		else
		begin
			line_tx <= tx_sh[0];
			if (tx_cnt != 32'h0)
				tx_cnt <= tx_cnt - 32'h1;
			else
			begin
				tx_cnt <= 32'(BIT_CYC - 1);
				tx_sh <= {1'b1, tx_sh[10:1]};
				tx_bit <= tx_bit + 4'h1;
				tx_act <= tx_bit != 4'ha;
			end
		end
	end
endmodule

// ==== rsh_slave.sv ====
/*
 Slave request handler: frames requests from the line, checks address and
 checksum, executes supported functions and sends the response.
 Assumes a half-duplex line whose driver is enabled by line_de.
*/
`timescale 1ns/100ps
`include "rsh_defines.svh"
module rsh_slave #(
	parameter int         BIT_CYC  = `RSH_BIT_CYC,
	parameter int         GAP_CYC  = `RSH_GAP_CYC,
	parameter int         SIL_CYC  = `RSH_SIL_CYC,
	parameter int         NREG     = 16,
	parameter int         NIN      = 16,
	parameter int         MAXB     = 48,
	parameter logic [7:0] SLAVE_ID = 8'h5a
) (
	input  wire logic                ref_clk,
	input  wire logic                reset,
	input  wire logic                line_rx,
	output logic                     line_tx,
	output logic                     line_de,
	input  wire logic [7:0]          slave_addr_pin,
	input  wire logic                parity_en_pin,
	input  wire logic                parity_odd_pin,
	input  wire logic [NIN*16-1:0]   input_regs,
	output logic      [3:0]          coil_on,
	output logic      [NREG*16-1:0]  hold_regs
);
	// Slave identity byte above is arbitrary.

	// ----------------------------------------
	// Configuration pins and line serializer
	// ----------------------------------------
	logic [9:0] cfg_meta;
	logic [9:0] cfg_sync;
	wire  [7:0] my_addr = cfg_sync[7:0];

	always_ff @(posedge ref_clk)
	begin
		cfg_meta <= {parity_odd_pin, parity_en_pin, slave_addr_pin};
		cfg_sync <= cfg_meta;
	end

	rsh_char_if chr ();
	assign chr.parity_en = cfg_sync[8];
	assign chr.parity_odd = cfg_sync[9];

	rsh_uart #(
		.BIT_CYC (BIT_CYC)
	) u_uart (
		.ref_clk (ref_clk),
		.reset   (reset),
		.line_rx (line_rx),
		.line_tx (line_tx),
		.chr     (chr)
	);

	// ----------------------------------------
	// Frame reception
	// ----------------------------------------
	rsh_pkg::rsh_state_type state;
	logic [7:0]  rbuf [MAXB];
	logic [5:0]  nrx;
	logic        bad;
	logic        gapped;
	logic [31:0] idle;
	logic [15:0] rx_crc;
	logic [15:0] rx_crc_next;
	wire         restart = nrx == 6'h0 || gapped;
	wire         at_gap = idle == 32'(GAP_CYC);
	wire         at_sil = idle == 32'(SIL_CYC);

	rsh_crc16 u_rx_crc (
		.crc_in  (restart ? `RSH_CRC_INIT : rx_crc),
		.data    (chr.rx_data),
		.crc_out (rx_crc_next)
	);

	always_ff @(posedge ref_clk)
	begin
		if (reset || chr.rx_busy || chr.rx_valid || state == rsh_pkg::RSH_TX)
			idle <= 32'h0;
		else if (!at_sil)
			idle <= idle + 32'h1;
	end

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	wire [7:0]  fc = rbuf[1];
	wire [15:0] start = {rbuf[2], rbuf[3]};
	wire [15:0] qty = {rbuf[4], rbuf[5]};
	wire [16:0] stop17 = {1'b0, start} + {1'b0, qty};
	wire        bcast = rbuf[0] == `RSH_BCAST;
	wire        own = rbuf[0] == my_addr && my_addr != `RSH_BCAST
		&& my_addr <= `RSH_ADDR_MAX;
	wire        frame_ok = !bad && rx_crc == 16'h0000 && nrx >= 6'h4;
	wire        f_rdc = fc == `RSH_FC_RD_COIL;
	wire        f_rdh = fc == `RSH_FC_RD_HOLD;
	wire        f_rdi = fc == `RSH_FC_RD_IN;
	wire        f_wc = fc == `RSH_FC_WR_COIL;
	wire        f_wr = fc == `RSH_FC_WR_REG;
	wire        f_wcs = fc == `RSH_FC_WR_COILS;
	wire        f_wrs = fc == `RSH_FC_WR_REGS;
	wire        f_id = fc == `RSH_FC_REP_ID;
	wire        f_known = f_rdc || f_rdh || f_rdi || f_wc || f_wr || f_wcs || f_wrs
		|| f_id || fc == `RSH_FC_RESET;
	wire        coil_rng = qty != 16'h0 && stop17 <= 17'(`RSH_NUM_COILS);
	wire        hold_rng = qty != 16'h0 && stop17 <= 17'(NREG);
	wire        in_rng = qty != 16'h0 && stop17 <= 17'(NIN);
	wire        addr_bad = ((f_rdc || f_wcs) && !coil_rng) || ((f_rdh || f_wrs) && !hold_rng)
		|| (f_rdi && !in_rng) || (f_wc && start >= 16'(`RSH_NUM_COILS))
		|| (f_wr && start >= 16'(NREG));
	wire        val_bad = (f_wc && qty != `RSH_COIL_ON && qty != `RSH_COIL_OFF)
		|| (f_wrs && {8'h00, rbuf[6]} != {qty[14:0], 1'b0});
	wire [7:0]  exc = !f_known ? `RSH_EXC_FUNC : addr_bad ? `RSH_EXC_ADDR
		: val_bad ? `RSH_EXC_VAL : 8'h00;
	wire        do_write = state == rsh_pkg::RSH_EXEC && frame_ok && (own || bcast)
		&& exc == 8'h00;
	wire [5:0]  rd_len = 6'(qty[4:0] * 2 + 3);
	wire [5:0]  len_now = exc != 8'h00 ? 6'h3 : f_rdc ? 6'h4 : (f_rdh || f_rdi) ? rd_len
		: f_id ? 6'h5 : 6'h6;

	// ----------------------------------------
	// Coils and holding registers
	// ----------------------------------------
	logic [15:0] hold [NREG];
	logic [15:0] inw [NIN];
	logic [3:0]  next_coil;
	logic [15:0] next_hold [NREG];

	generate
		for (genvar i = 0; i < `RSH_NUM_COILS; i++)
		begin : g_coil
			wire [15:0] off = 16'(i) - start;
			wire        hit = 17'(i) >= {1'b0, start} && 17'(i) < stop17;
			assign next_coil[i] = (f_wc && start == 16'(i)) ? qty == `RSH_COIL_ON
				: (f_wcs && hit) ? rbuf[7][off[2:0]] : coil_on[i];
		end
		for (genvar i = 0; i < NREG; i++)
		begin : g_hold
			wire [15:0] off = 16'(i) - start;
			wire [5:0]  pos = 6'(7 + 2 * off[4:0]);
			wire        hit = 17'(i) >= {1'b0, start} && 17'(i) < stop17;
			assign next_hold[i] = (f_wr && start == 16'(i)) ? qty
				: (f_wrs && hit) ? {rbuf[pos], rbuf[pos + 6'h1]} : hold[i];
			assign hold_regs[i*16 +: 16] = hold[i];
			always_ff @(posedge ref_clk)
			begin
				if (reset)
					hold[i] <= 16'h0000;
				else if (do_write)
					hold[i] <= next_hold[i];
			end
		end
		for (genvar i = 0; i < NIN; i++)
		begin : g_in
			assign inw[i] = input_regs[i*16 +: 16];
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			coil_on <= 4'h0;
		else if (do_write)
			coil_on <= next_coil;
	end

	// ----------------------------------------
	// Response assembly
	// ----------------------------------------
	logic [5:0]  k;
	logic [5:0]  resp_len;
	logic [7:0]  exc_q;
	logic [15:0] tx_crc;
	logic [15:0] tx_crc_next;
	logic [7:0]  rb;
	wire  [5:0]  koff = k - 6'h3;
	wire  [15:0] ridx = start + {11'h000, koff[5:1]};
	wire  [15:0] word = f_rdh ? hold[ridx[$clog2(NREG)-1:0]] : inw[ridx[$clog2(NIN)-1:0]];
	wire  [7:0]  cmask = 8'((9'h001 << qty[3:0]) - 9'h001);
	wire  [7:0]  cbits = ({4'h0, coil_on} >> start[1:0]) & cmask;
	wire         tx_more = k < resp_len + 6'h2;

	always_comb
	begin
		rb = 8'h00;
		if (k == 6'h0)
			rb = my_addr;
		else if (k == 6'h1)
			rb = exc_q != 8'h00 ? (fc | `RSH_EXC_FLAG) : fc;
		else if (exc_q != 8'h00)
			rb = exc_q;
		else if (f_rdc)
			rb = k == 6'h2 ? 8'h01 : cbits;
		else if (f_rdh || f_rdi)
			rb = k == 6'h2 ? {qty[6:0], 1'b0} : koff[0] ? word[7:0] : word[15:8];
		else if (f_id)
			rb = k == 6'h2 ? 8'h02 : k == 6'h3 ? SLAVE_ID : `RSH_RUN_ON;
		else
			rb = rbuf[k];
	end

	assign chr.tx_valid = state == rsh_pkg::RSH_TX && tx_more;
	assign chr.tx_data = k < resp_len ? rb : k == resp_len ? tx_crc[7:0] : tx_crc[15:8];

	rsh_crc16 u_tx_crc (
		.crc_in  (tx_crc),
		.data    (rb),
		.crc_out (tx_crc_next)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state <= rsh_pkg::RSH_SYNC;
			nrx <= 6'h0;
			bad <= 1'b0;
			gapped <= 1'b0;
			rx_crc <= `RSH_CRC_INIT;
			k <= 6'h0;
			resp_len <= 6'h0;
			exc_q <= 8'h00;
			tx_crc <= `RSH_CRC_INIT;
			line_de <= 1'b0;
		end
		else
		begin
			unique case (state)
				rsh_pkg::RSH_SYNC:
				begin
					nrx <= 6'h0;
					if (at_sil)
						state <= rsh_pkg::RSH_RECV;
				end
				rsh_pkg::RSH_RECV:
				begin
					if (at_gap && nrx != 6'h0)
						gapped <= 1'b1;
					if (chr.rx_valid)
					begin
						gapped <= 1'b0;
						rx_crc <= rx_crc_next;
						if (restart)
						begin
							rbuf[0] <= chr.rx_data;
							nrx <= 6'h1;
							bad <= chr.rx_err;
						end
						else if (nrx < 6'(MAXB))
						begin
							rbuf[nrx] <= chr.rx_data;
							nrx <= nrx + 6'h1;
							bad <= bad || chr.rx_err;
						end
						else
							bad <= 1'b1;
					end
					else if (at_sil && nrx != 6'h0)
					begin
						state <= rsh_pkg::RSH_EXEC;
						gapped <= 1'b0;
					end
				end
				rsh_pkg::RSH_EXEC:
				begin
					nrx <= 6'h0;
					exc_q <= exc;
					resp_len <= len_now;
					k <= 6'h0;
					tx_crc <= `RSH_CRC_INIT;
					if (frame_ok && own && !bcast)
					begin
						state <= rsh_pkg::RSH_TX;
						line_de <= 1'b1;
					end
					else
						state <= rsh_pkg::RSH_RECV;
				end
				rsh_pkg::RSH_TX:
				begin
					if (chr.tx_valid && chr.tx_ready)
					begin
						k <= k + 6'h1;
						if (k < resp_len)
							tx_crc <= tx_crc_next;
					end
					else if (!tx_more && !chr.tx_busy)
					begin
						line_de <= 1'b0;
						state <= rsh_pkg::RSH_RECV;
					end
				end
			endcase
		end
	end
endmodule

// ==== rsh_slave_asserts.sv ====
/*
 Checker for the slave request handler, bound to its top module.
 Assumes only the top module's ports and a single clock domain.
*/
`timescale 1ns/100ps
module rsh_slave_asserts #(
	parameter int BIT_CYC = 16,
	parameter int SIL_CYC = 616,
	parameter int NREG    = 16,
	parameter int NIN     = 16
) (
	input wire logic               ref_clk,
	input wire logic               reset,
	input wire logic               line_rx,
	input wire logic               line_tx,
	input wire logic               line_de,
	input wire logic [7:0]         slave_addr_pin,
	input wire logic               parity_en_pin,
	input wire logic               parity_odd_pin,
	input wire logic [NIN*16-1:0]  input_regs,
	input wire logic [3:0]         coil_on,
	input wire logic [NREG*16-1:0] hold_regs
);
	// ----
	// Counters of idle, drive and high-level time
	// ----
	int idle_cnt;
	int de_cnt;
	int hi_cnt;

	always_ff @(posedge ref_clk)
	begin
		idle_cnt <= (reset || !line_rx) ? 0 : idle_cnt + 1;
		de_cnt   <= (reset || !line_de) ? 0 : de_cnt + 1;
		hi_cnt   <= (reset || !line_tx) ? 0 : hi_cnt + 1;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_lead;
		line_tx ##1 line_tx ##[1:2] !line_tx;
	endsequence
	sequence s_start;
		(line_de && !line_tx) [*8];
	endsequence

	property p_tx_idle; !line_de |-> line_tx; endproperty
	property p_lead; $rose(line_de) |-> s_lead; endproperty
	property p_start; $fell(line_tx) |-> s_start; endproperty
	property p_sil; $rose(line_de) |-> idle_cnt >= SIL_CYC; endproperty
	// A response holds at least address, code, reason and two check bytes.
	property p_min_len; $fell(line_de) |-> de_cnt >= 55 * BIT_CYC; endproperty
	property p_stop; $fell(line_de) |-> hi_cnt >= BIT_CYC - 1; endproperty
	property p_coil_hold; line_de && $past(line_de) |-> $stable(coil_on); endproperty
	property p_hold_hold; line_de && $past(line_de) |-> $stable(hold_regs); endproperty

	a_tx_idle: assert property (p_tx_idle) else $error("tx low while idle");
	a_lead: assert property (p_lead) else $error("bad start after enable");
	a_start: assert property (p_start) else $error("short start bit");
	a_sil: assert property (p_sil) else $error("reply before silence");
	a_min_len: assert property (p_min_len) else $error("reply too short");
	a_stop: assert property (p_stop) else $error("stop bit cut short");
	a_coil_hold: assert property (p_coil_hold) else $error("coils moved in reply");
	a_hold_hold: assert property (p_hold_hold) else $error("regs moved in reply");
endmodule

bind rsh_slave rsh_slave_asserts #(
	.BIT_CYC(BIT_CYC),
	.SIL_CYC(SIL_CYC),
	.NREG(NREG),
	.NIN(NIN)
) rsh_slave_asserts_i (
	.ref_clk(ref_clk), .reset(reset), .line_rx(line_rx), .line_tx(line_tx),
	.line_de(line_de), .slave_addr_pin(slave_addr_pin), .parity_en_pin(parity_en_pin),
	.parity_odd_pin(parity_odd_pin), .input_regs(input_regs), .coil_on(coil_on),
	.hold_regs(hold_regs)
);

// ==== rsh_master.sv ====
/*
 Master model on the far side of the serial line: sends requests and
 collects response characters with their framing errors.
 Assumes the line is biased high when no party drives it.
*/
`timescale 1ns/100ps
module rsh_master #(
	parameter int BIT_CYC = 16
) (
	input  wire logic ref_clk,
	input  wire logic line_tx,
	input  wire logic line_de,
	input  wire logic parity_en,
	input  wire logic parity_odd,
	output logic      line_rx
);
	logic [7:0] rsp[$];
	int         frame_errs = 0;

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic send_byte(input logic [7:0] b, input logic flip);
		logic [10:0] f;
		f = {1'b1, (parity_en ? ^b ^ parity_odd : 1'b1) ^ flip, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge ref_clk);
			line_rx <= f[i];
			repeat (BIT_CYC - 1) @(posedge ref_clk);
		end
	endtask

	// Mode 1 spoils the check field, mode 2 leaves it out, mode 3 inverts the bit after the data.
	task automatic send_frame(input logic [7:0] q[$], input int mode);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0000, mode == 1};
		if (mode != 2)
		begin
			q.push_back(c[7:0]);
			q.push_back(c[15:8]);
		end
		foreach (q[i]) send_byte(q[i], mode == 3);
	endtask

	initial line_rx = 1'b1;

	initial
	begin
		logic [7:0] b;
		logic       p;
		logic       s;
		forever
		begin
			@(posedge ref_clk);
			if (line_de === 1'b1 && line_tx === 1'b0)
			begin
				repeat (BIT_CYC / 2) @(posedge ref_clk);
				for (int i = 0; i < 8; i++)
				begin
					repeat (BIT_CYC) @(posedge ref_clk);
					b[i] = line_tx;
				end
				repeat (BIT_CYC) @(posedge ref_clk);
				p = line_tx;
				repeat (BIT_CYC) @(posedge ref_clk);
				s = line_tx;
				if (p !== (parity_en ? ^b ^ parity_odd : 1'b1) || s !== 1'b1)
					frame_errs++;
				rsp.push_back(b);
			end
		end
	end
endmodule

// ==== rsh_slave_bench.sv ====
/*
 Self-checking bench of the slave request handler with a master model.
 Assumes shortened bit, gap and silence counts set here.
*/
`timescale 1ns/100ps
module rsh_slave_bench;
	localparam int BIT = 8;
	localparam int GAP = 132;
	localparam int SIL = 308;

	logic         ref_clk;
	logic         reset;
	logic         line_rx;
	logic         line_tx;
	logic         line_de;
	logic         par_en;
	logic         par_odd;
	logic [7:0]   addr;
	logic [255:0] input_regs;
	logic [3:0]   coil_on;
	logic [255:0] hold_regs;
	int           err_count;
	int           checked;

	rsh_slave #(.BIT_CYC(BIT), .GAP_CYC(GAP), .SIL_CYC(SIL)) rsh_slave_i (
		.ref_clk(ref_clk), .reset(reset), .line_rx(line_rx), .line_tx(line_tx),
		.line_de(line_de), .slave_addr_pin(addr), .parity_en_pin(par_en),
		.parity_odd_pin(par_odd), .input_regs(input_regs), .coil_on(coil_on),
		.hold_regs(hold_regs));

	rsh_master #(.BIT_CYC(BIT)) rsh_master_i (
		.ref_clk(ref_clk), .line_tx(line_tx), .line_de(line_de), .parity_en(par_en),
		.parity_odd(par_odd), .line_rx(line_rx));

	// ----
	// Shared tasks
	// ----
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Sends rn bytes of rv; expects en reply bytes ev plus check field, none if en is 0.
	task automatic xact(input logic [95:0] rv, input int rn, input logic [95:0] ev,
		input int en, input int mode);
		logic [7:0] q[$];
		int         n;
		n = 0;
		for (int i = 0; i < rn; i++) q.push_back(rv[8 * (rn - 1 - i) +: 8]);
		rsh_master_i.rsp.delete();
		rsh_master_i.frame_errs = 0;
		rsh_master_i.send_frame(q, mode);
		while (line_de !== 1'b1 && n < SIL + 300) @(posedge ref_clk) n++;
		check("reply", line_de, en != 0);
		if (line_de !== 1'b1)
			return;
		n = 0;
		while (line_de === 1'b1 && n < 20000) @(posedge ref_clk) n++;
		if (n >= 20000)
		begin
			err_count++;
			give_verdict();
		end
		repeat (SIL) @(posedge ref_clk);
		check("length", rsh_master_i.rsp.size(), en + 2);
		for (int i = 0; i < en; i++)
			check("byte", rsh_master_i.rsp[i], ev[8 * (en - 1 - i) +: 8]);
		check("crc", rsh_master_i.crc16(rsh_master_i.rsp), 32'h0);
		check("framing", rsh_master_i.frame_errs, 32'h0);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_coils();
		xact(48'hf7_05_00_01_ff_00, 6, 48'hf7_05_00_01_ff_00, 6, 0);
		xact(48'hf7_05_00_03_ff_00, 6, 48'hf7_05_00_03_ff_00, 6, 0);
		xact(48'hf7_05_00_02_12_34, 6, 24'hf7_85_03, 3, 0);
		check("coils", coil_on, 4'b1010);
		xact(48'hf7_01_00_00_00_04, 6, 32'hf7_01_01_0a, 4, 0);
		xact(48'hf7_01_00_01_00_03, 6, 32'hf7_01_01_05, 4, 0);
		xact(48'hf7_01_00_04_00_01, 6, 24'hf7_81_02, 3, 0);
	endtask

	task automatic t_regs();
		xact(48'hf7_06_00_02_12_34, 6, 48'hf7_06_00_02_12_34, 6, 0);
		check("hold", hold_regs[47:32], 16'h1234);
		xact(48'hf7_03_00_01_00_03, 6, 72'hf7_03_06_00_00_12_34_00_00, 9, 0);
		xact(48'hf7_03_00_0f_00_02, 6, 24'hf7_83_02, 3, 0);
		xact(48'hf7_04_00_00_00_02, 6, 56'hf7_04_04_00_50_00_80, 7, 0);
	endtask

	task automatic t_codes();
		xact(48'hf7_07_00_00_00_01, 6, 24'hf7_87_01, 3, 0);
		xact(48'hf7_08_00_00_12_34, 6, 48'hf7_08_00_00_12_34, 6, 0);
		xact(16'hf7_11, 2, 40'hf7_11_02_5a_ff, 5, 0);
		check("coils", coil_on, 4'b1010);
		xact(64'hf7_0f_00_00_00_04_01_05, 8, 48'hf7_0f_00_00_00_04, 6, 0);
		check("coils", coil_on, 4'b0101);
		xact(72'hf7_10_00_03_00_01_02_ab_cd, 9, 48'hf7_10_00_03_00_01, 6, 0);
		check("hold", hold_regs[63:48], 16'habcd);
		xact(72'hf7_10_00_03_00_01_03_ab_cd, 9, 24'hf7_90_03, 3, 0);
	endtask

	task automatic t_bcast();
		xact(48'h00_05_00_01_ff_00, 6, '0, 0, 0);
		check("coils", coil_on, 4'b0111);
		xact(48'h00_01_00_00_00_04, 6, '0, 0, 0);
		xact(48'h22_05_00_03_ff_00, 6, '0, 0, 0);
		xact(48'hf7_05_00_03_ff_00, 6, '0, 0, 1);
		check("coils", coil_on, 4'b0111);
	endtask

	// A stale fragment must be flushed by the gap, or the check field fails.
	task automatic t_gap();
		rsh_master_i.send_frame('{8'hf7, 8'h05}, 2);
		repeat (GAP + 40) @(posedge ref_clk);
		xact(48'hf7_01_00_00_00_04, 6, 32'hf7_01_01_07, 4, 0);
	endtask

	task automatic t_parity();
		par_en <= 1'b1;
		par_odd <= 1'b1;
		repeat (20) @(posedge ref_clk);
		xact(48'hf7_01_00_00_00_04, 6, 32'hf7_01_01_07, 4, 0);
		xact(48'hf7_05_00_03_ff_00, 6, '0, 0, 3);
		check("coils", coil_on, 4'b0111);
		par_odd <= 1'b0;
		repeat (20) @(posedge ref_clk);
		xact(48'hf7_01_00_00_00_04, 6, 32'hf7_01_01_07, 4, 0);
		par_en <= 1'b0;
		repeat (20) @(posedge ref_clk);
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		reset = 1'b1;
		par_en = 1'b0;
		par_odd = 1'b0;
		addr = 8'hf7;
		input_regs = {224'h0, 32'h0080_0050};
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (SIL + 20) @(posedge ref_clk);
		t_coils();
		t_regs();
		t_codes();
		t_bcast();
		t_gap();
		t_parity();
		give_verdict();
	end
endmodule
